// file: inc/ssc_pkg.sv
/*
  Constants, register map and carrier types for the sensor configuration
  and control bank. Assumes a byte-wide register write port and a
  word-wide read port driven by the serial front end on core_clk.
*/
package ssc_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses (low byte of each word)
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_AUX_LEVEL = 7'h30;
   localparam logic [6:0] ADDR_LINE_CTRL = 7'h32;
   localparam logic [6:0] ADDR_MISC_CTRL = 7'h34;
   localparam logic [6:0] ADDR_RANGE_CFG = 7'h38;
   localparam logic [6:0] ADDR_COMMAND = 7'h3e;
   // ----------------------------------------------------------------
   // Reset values and field masks
   // ----------------------------------------------------------------
   localparam logic [15:0] RANGE_CFG_RESET = 16'h0402;
   localparam logic [15:0] AUX_LEVEL_RESET = 16'h0000;
   localparam logic [15:0] AUX_LEVEL_MASK = 16'h0fff;
   localparam logic [15:0] LINE_CTRL_MASK = 16'h0303;
   localparam logic [15:0] MISC_CTRL_MASK = 16'h07c7;
   localparam logic [15:0] RANGE_CFG_MASK = 16'h0707;
   // Field positions
   localparam int MISC_SELFTEST_BIT = 10;
   localparam int MISC_NEG_STIM_BIT = 9;
   localparam int MISC_POS_STIM_BIT = 8;
   localparam int MISC_BIAS_COMP_BIT = 7;
   localparam int MISC_ORIGIN_BIT = 6;
   localparam int MISC_DRDY_EN_BIT = 2;
   localparam int MISC_DRDY_POL_BIT = 1;
   localparam int MISC_DRDY_SEL_BIT = 0;
   localparam int CMD_LATCH_BIT = 2;
   localparam int STATUS_SELFTEST_BIT = 5;
   // Range encodings and least filter settings
   localparam logic [2:0] RANGE_WIDE = 3'h4;
   localparam logic [2:0] RANGE_MID = 3'h2;
   localparam logic [2:0] RANGE_NARROW = 3'h1;
   localparam logic [2:0] MIN_FILT_MID = 3'h2;
   localparam logic [2:0] MIN_FILT_NARROW = 3'h4;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SELFTEST_TIME_MS = 35;
   localparam longint SELFTEST_CYCLES =
      (longint'(SELFTEST_TIME_MS) * 64'd1000000000) / CLK_PERIOD_PS;
   localparam logic [5:0] DRDY_PULSE_CYCLES = 6'h20;
   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SSC_RANGE_WIDE,
      SSC_RANGE_MID,
      SSC_RANGE_NARROW
   } ssc_range_t;
   typedef struct packed {
      logic en;          // One-cycle byte write strobe
      logic [6:0] addr;  // Byte address
      logic [7:0] data;  // Byte to write
   } ssc_wr_t;
   typedef struct packed {
      ssc_range_t range; // Selected rate range
      logic [2:0] filt_m; // Filter exponent
      logic [7:0] taps;  // Tap count, 2**M
   } ssc_filt_t;
endpackage

// file: verilog/ssc_bank.sv
/*
  Sensor configuration and control register bank: range and filter
  setup, staged converter level with latch, two general lines with
  data-ready and alarm overlay, self-test sequencing and enables.
  Assumes the serial front end issues byte writes and word reads on
  core_clk; line pins arrive asynchronously.
*/
`timescale 1ns/1ps
module ssc_bank #(
   parameter longint SELFTEST_CYCLES = ssc_pkg::SELFTEST_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire ssc_pkg::ssc_wr_t wr_req,
   input wire logic [6:0] rd_addr,
   output logic [15:0] rd_data,
   input wire logic nv_load,
   input wire logic [15:0] nv_word,
   output logic [15:0] nv_range_word,
   output ssc_pkg::ssc_filt_t filt_cfg,
   output logic [11:0] aux_level_out,
   input wire logic [1:0] line_in,
   output logic [1:0] line_out,
   output logic [1:0] line_oe,
   input wire logic [1:0] alarm_line_en,
   input wire logic [1:0] alarm_line_lvl,
   input wire logic data_update,
   output logic selftest_active,
   input wire logic selftest_fail,
   input wire logic status_clear,
   output logic status_selftest_err,
   output logic stim_neg,
   output logic stim_pos,
   output logic bias_comp_en,
   output logic origin_align_en
);
   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   // Least filter exponent allowed for a range pattern
   function automatic logic [2:0] min_filt(input logic [2:0] rng);
      case (rng)
         ssc_pkg::RANGE_MID: min_filt = ssc_pkg::MIN_FILT_MID;
         ssc_pkg::RANGE_NARROW: min_filt = ssc_pkg::MIN_FILT_NARROW;
         default: min_filt = 3'h0;
      endcase
   endfunction
   // Raise a filter exponent to the range minimum
   function automatic logic [2:0] clamp_filt(input logic [2:0] m, input logic [2:0] rng);
      clamp_filt = (m < min_filt(rng)) ? min_filt(rng) : m;
   endfunction
   // True when a write targets a given byte
   function automatic logic hit(input ssc_pkg::ssc_wr_t w, input logic [6:0] a);
      hit = w.en && (w.addr == a);
   endfunction

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0] range_cfg_reg;   // Range and filter word
   logic [15:0] aux_stage_reg;   // Staged converter word
   logic [11:0] aux_latch_reg;   // Driven converter level
   logic [15:0] line_ctrl_reg;   // Line direction and levels
   logic [15:0] misc_ctrl_reg;   // Misc function control
   logic [1:0] line_meta_reg;    // First sync stage, read by second only
   logic [1:0] line_sync_reg;    // Sampled pin levels
   logic [5:0] drdy_cnt_reg;     // Data-ready pulse remaining
   logic [31:0] st_cnt_reg;      // Self-test cycles elapsed
   logic st_err_reg;             // Self-test failure flag
   logic [1:0] line_out_reg;
   logic [1:0] line_oe_reg;
   logic [15:0] rd_data_reg;
   logic st_done;                // Last cycle of the self-test

   localparam logic [31:0] ST_LAST = 32'(SELFTEST_CYCLES - 1);

   // ----------------------------------------------------------------
   // Range and filter configuration
   // ----------------------------------------------------------------
   // Non-one-hot range bytes are dropped; any range byte write drags the
   // filter up to the new minimum so resolution is never lost even if
   // the host writes bytes in the wrong order.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         range_cfg_reg <= ssc_pkg::RANGE_CFG_RESET;
      end else if (nv_load) begin
         // Restore from nonvolatile store
         range_cfg_reg <= nv_word & ssc_pkg::RANGE_CFG_MASK;
      end else if (hit(wr_req, ssc_pkg::ADDR_RANGE_CFG + 7'h1)) begin
         if (wr_req.data[2:0] == ssc_pkg::RANGE_WIDE ||
             wr_req.data[2:0] == ssc_pkg::RANGE_MID ||
             wr_req.data[2:0] == ssc_pkg::RANGE_NARROW) begin
            range_cfg_reg[10:8] <= wr_req.data[2:0];
            range_cfg_reg[2:0] <= clamp_filt(range_cfg_reg[2:0], wr_req.data[2:0]);
         end
      end else if (hit(wr_req, ssc_pkg::ADDR_RANGE_CFG)) begin
         range_cfg_reg[2:0] <= clamp_filt(wr_req.data[2:0], range_cfg_reg[10:8]);
      end
   end
   assign nv_range_word = range_cfg_reg;

   // Range decode and tap count
   always_comb begin
      case (range_cfg_reg[10:8])
         ssc_pkg::RANGE_MID: filt_cfg.range = ssc_pkg::SSC_RANGE_MID;
         ssc_pkg::RANGE_NARROW: filt_cfg.range = ssc_pkg::SSC_RANGE_NARROW;
         default: filt_cfg.range = ssc_pkg::SSC_RANGE_WIDE;
      endcase
      filt_cfg.filt_m = range_cfg_reg[2:0];
      filt_cfg.taps = 8'h01 << range_cfg_reg[2:0];
   end

   // ----------------------------------------------------------------
   // Auxiliary converter staging and latch
   // ----------------------------------------------------------------
   // Staged word takes byte writes; volatile, so reset clears it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aux_stage_reg <= ssc_pkg::AUX_LEVEL_RESET;
      end else if (hit(wr_req, ssc_pkg::ADDR_AUX_LEVEL)) begin
         aux_stage_reg[7:0] <= wr_req.data;
      end else if (hit(wr_req, ssc_pkg::ADDR_AUX_LEVEL + 7'h1)) begin
         aux_stage_reg[15:8] <= wr_req.data & 8'h0f;
      end
   end

   // Output latch moves only on the latch command, never on byte writes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aux_latch_reg <= 12'h000;
      end else if (hit(wr_req, ssc_pkg::ADDR_COMMAND) &&
                   wr_req.data[ssc_pkg::CMD_LATCH_BIT]) begin
         aux_latch_reg <= aux_stage_reg[11:0];
      end
   end
   assign aux_level_out = aux_latch_reg;

   // ----------------------------------------------------------------
   // General line control
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         line_ctrl_reg <= 16'h0000;
      end else if (hit(wr_req, ssc_pkg::ADDR_LINE_CTRL)) begin
         line_ctrl_reg[1:0] <= wr_req.data[1:0];
      end else if (hit(wr_req, ssc_pkg::ADDR_LINE_CTRL + 7'h1)) begin
         line_ctrl_reg[9:8] <= wr_req.data[1:0];
      end
   end

   // Two-stage synchroniser on the pin inputs
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         line_meta_reg <= 2'h0;
         line_sync_reg <= 2'h0;
      end else begin
         line_meta_reg <= line_in;
         line_sync_reg <= line_meta_reg;
      end
   end

   // Data-ready pulse stretcher; a new update restarts the pulse
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drdy_cnt_reg <= 6'h00;
      end else if (data_update && misc_ctrl_reg[ssc_pkg::MISC_DRDY_EN_BIT]) begin
         drdy_cnt_reg <= ssc_pkg::DRDY_PULSE_CYCLES;
      end else if (drdy_cnt_reg != 6'h00) begin
         drdy_cnt_reg <= drdy_cnt_reg - 6'h01;
      end
   end

   // Pin drivers, registered so the pins never glitch between owners
   generate
      for (genvar i = 0; i < 2; i++) begin : g_line
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               line_out_reg[i] <= 1'b0;
               line_oe_reg[i] <= 1'b0;
            end else if (misc_ctrl_reg[ssc_pkg::MISC_DRDY_EN_BIT] &&
                         misc_ctrl_reg[ssc_pkg::MISC_DRDY_SEL_BIT] == 1'(i)) begin
               // Data-ready owns the line first
               line_oe_reg[i] <= 1'b1;
               line_out_reg[i] <= (drdy_cnt_reg != 6'h00) ~^
                                  misc_ctrl_reg[ssc_pkg::MISC_DRDY_POL_BIT];
            end else if (alarm_line_en[i]) begin
               // Alarm indication second
               line_oe_reg[i] <= 1'b1;
               line_out_reg[i] <= alarm_line_lvl[i];
            end else begin
               // Plain line control last
               line_oe_reg[i] <= line_ctrl_reg[i];
               line_out_reg[i] <= line_ctrl_reg[8 + i];
            end
         end
      end
   endgenerate
   assign line_out = line_out_reg;
   assign line_oe = line_oe_reg;

   // ----------------------------------------------------------------
   // Misc control and self-test
   // ----------------------------------------------------------------
   assign st_done = misc_ctrl_reg[ssc_pkg::MISC_SELFTEST_BIT] && (st_cnt_reg == ST_LAST);

   // Self-test bit may be set by the host but only hardware clears it;
   // a running test cannot be aborted by writing zero.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         misc_ctrl_reg <= 16'h0000;
      end else begin
         if (hit(wr_req, ssc_pkg::ADDR_MISC_CTRL)) begin
            misc_ctrl_reg[7:6] <= wr_req.data[7:6];
            misc_ctrl_reg[2:0] <= wr_req.data[2:0];
         end
         if (hit(wr_req, ssc_pkg::ADDR_MISC_CTRL + 7'h1)) begin
            misc_ctrl_reg[9:8] <= wr_req.data[1:0];
            if (wr_req.data[2]) begin
               misc_ctrl_reg[10] <= 1'b1;
            end else if (st_done) begin
               misc_ctrl_reg[10] <= 1'b0;
            end
         end else if (st_done) begin
            misc_ctrl_reg[10] <= 1'b0;
         end
      end
   end

   // Self-test duration counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_cnt_reg <= 32'h0;
      end else if (!misc_ctrl_reg[ssc_pkg::MISC_SELFTEST_BIT] || st_done) begin
         st_cnt_reg <= 32'h0;
      end else begin
         st_cnt_reg <= st_cnt_reg + 32'h1;
      end
   end

   // Failure flag: set at test end wins over a status read clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_err_reg <= 1'b0;
      end else if (st_done && selftest_fail) begin
         st_err_reg <= 1'b1;
      end else if (status_clear) begin
         st_err_reg <= 1'b0;
      end
   end

   assign status_selftest_err = st_err_reg;
   assign selftest_active = misc_ctrl_reg[ssc_pkg::MISC_SELFTEST_BIT];
   assign stim_neg = misc_ctrl_reg[ssc_pkg::MISC_NEG_STIM_BIT];
   assign stim_pos = misc_ctrl_reg[ssc_pkg::MISC_POS_STIM_BIT];
   assign bias_comp_en = misc_ctrl_reg[ssc_pkg::MISC_BIAS_COMP_BIT];
   assign origin_align_en = misc_ctrl_reg[ssc_pkg::MISC_ORIGIN_BIT];

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Word read by even address; one cycle of latency. Command word is
   // write-only and reads zero like any unmapped address.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_data_reg <= 16'h0000;
      end else begin
         case ({rd_addr[6:1], 1'b0})
            ssc_pkg::ADDR_AUX_LEVEL: rd_data_reg <= aux_stage_reg & ssc_pkg::AUX_LEVEL_MASK;
            ssc_pkg::ADDR_LINE_CTRL: begin
               rd_data_reg <= 16'h0000;
               rd_data_reg[1:0] <= line_ctrl_reg[1:0];
               for (int k = 0; k < 2; k++) begin
                  rd_data_reg[8 + k] <= line_ctrl_reg[k] ? line_ctrl_reg[8 + k]
                                                         : line_sync_reg[k];
               end
            end
            ssc_pkg::ADDR_MISC_CTRL: rd_data_reg <= misc_ctrl_reg & ssc_pkg::MISC_CTRL_MASK;
            ssc_pkg::ADDR_RANGE_CFG: rd_data_reg <= range_cfg_reg & ssc_pkg::RANGE_CFG_MASK;
            default: rd_data_reg <= 16'h0000;
         endcase
      end
   end
   assign rd_data = rd_data_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Range and filter word stays legal at every edge
   range_onehot_a: assert property (@(posedge core_clk) disable iff (rst)
      $onehot(range_cfg_reg[10:8])) else $error("range field not one-hot");
   filter_min_a: assert property (@(posedge core_clk) disable iff (rst)
      range_cfg_reg[2:0] >= min_filt(range_cfg_reg[10:8]))
      else $error("filter below range minimum");
   tap_count_a: assert property (@(posedge core_clk) disable iff (rst)
      $onehot(filt_cfg.taps) && filt_cfg.taps[range_cfg_reg[2:0]])
      else $error("tap count wrong");
   // Converter output moves only on the latch command
   aux_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !(wr_req.en && wr_req.addr == ssc_pkg::ADDR_COMMAND) |=> $stable(aux_level_out))
      else $error("converter level moved without latch");
   aux_latch_a: assert property (@(posedge core_clk) disable iff (rst)
      (hit(wr_req, ssc_pkg::ADDR_COMMAND) && wr_req.data[2])
      |=> aux_level_out == $past(aux_stage_reg[11:0]))
      else $error("latch did not load staged word");
   // Line ownership and data-ready level
   line_dir_a: assert property (@(posedge core_clk) disable iff (rst)
      (!misc_ctrl_reg[2] && alarm_line_en == 2'h0) ##1 (!misc_ctrl_reg[2] &&
      alarm_line_en == 2'h0) |-> line_oe == $past(line_ctrl_reg[1:0]))
      else $error("line direction mismatch");
   drdy_prio_a: assert property (@(posedge core_clk) disable iff (rst)
      misc_ctrl_reg[2] |=> line_oe[$past(misc_ctrl_reg[0])])
      else $error("data-ready line not driven");
   drdy_level_a: assert property (@(posedge core_clk) disable iff (rst)
      (misc_ctrl_reg[ssc_pkg::MISC_DRDY_EN_BIT] && data_update) ##1
      (misc_ctrl_reg[ssc_pkg::MISC_DRDY_EN_BIT] && $stable(misc_ctrl_reg[1:0]))
      |=> line_out[$past(misc_ctrl_reg[ssc_pkg::MISC_DRDY_SEL_BIT])] ==
      $past(misc_ctrl_reg[ssc_pkg::MISC_DRDY_POL_BIT]))
      else $error("data-ready level wrong");
   // Self-test length, self-clear and failure report; converter reset; misc read-back
   st_length_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(selftest_active) |-> selftest_active [*8])
      else $error("self-test ended too early");
   st_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      st_done |=> !selftest_active ||
      $past(hit(wr_req, ssc_pkg::ADDR_MISC_CTRL + 7'h1) && wr_req.data[2]))
      else $error("self-test bit not cleared");
   st_flag_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_done && selftest_fail) |=> status_selftest_err)
      else $error("self-test failure lost");
   aux_reset_a: assert property (@(posedge core_clk)
      $fell(rst) |-> aux_level_out == 12'h000 && aux_stage_reg == 16'h0000)
      else $error("converter not cleared by reset");
   misc_read_a: assert property (@(posedge core_clk) disable iff (rst)
      ($past({rd_addr[6:1], 1'b0}) == ssc_pkg::ADDR_MISC_CTRL)
      |-> (rd_data & ~ssc_pkg::MISC_CTRL_MASK) == 16'h0000)
      else $error("unused control bits read back");

   // Main scenarios worth seeing in a run
   cov_latch_c: cover property (@(posedge core_clk) disable iff (rst)
      hit(wr_req, ssc_pkg::ADDR_COMMAND) && wr_req.data[2]);
   cov_selftest_c: cover property (@(posedge core_clk) disable iff (rst) st_done);
   cov_narrow_c: cover property (@(posedge core_clk) disable iff (rst)
      filt_cfg.range == ssc_pkg::SSC_RANGE_NARROW);
   cov_drdy_c: cover property (@(posedge core_clk) disable iff (rst)
      misc_ctrl_reg[2] && data_update);
endmodule

// file: testbench/ssc_host.sv
/*
  Host model for the configuration bank: byte writes and word reads.
  Assumes the bench calls its tasks and that inputs move at falling edges.
*/
`timescale 1ns/1ps
module ssc_host (
   input wire logic core_clk,
   input wire logic [15:0] rd_data,
   output ssc_pkg::ssc_wr_t wr_req,
   output logic [6:0] rd_addr
);
   // ----------------------------------------------------------------
   // Port idle state
   // ----------------------------------------------------------------
   initial begin
      wr_req = '0;
      rd_addr = 7'h7f;
   end
   // One byte, strobe held across exactly one rising edge
   task automatic wr_byte(input logic [6:0] a, input logic [7:0] v);
      @(negedge core_clk);
      wr_req = '{en: 1'b1, addr: a, data: v};
      @(negedge core_clk);
      // Released bus shows garbage, not the last byte
      wr_req = '{en: 1'b0, addr: ~a, data: ~v};
   endtask
   // Word read: data is registered one cycle after the address
   task automatic rd_word(input logic [6:0] a, output logic [15:0] v);
      @(negedge core_clk);
      rd_addr = a;
      @(negedge core_clk);
      v = rd_data;
   endtask
   // Range byte goes first so the filter floor is already known
   task automatic set_range(input logic [7:0] r, input logic [7:0] m);
      wr_byte(7'h39, r);
      wr_byte(7'h38, m);
   endtask
   // Stage both converter bytes, low address first
   task automatic aux_stage(input logic [15:0] w);
      wr_byte(7'h30, w[7:0]);
      wr_byte(7'h31, w[15:8]);
   endtask
   // Latch command moves the staged word to the output
   task automatic aux_latch();
      wr_byte(7'h3e, 8'h04);
   endtask
endmodule

// file: testbench/ssc_bank_tb.sv
/*
  Self-checking bench for the configuration bank.
  Assumes ssc_host drives the register port; self-test shortened to 16.
*/
`timescale 1ns/1ps
module ssc_bank_tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   ssc_pkg::ssc_wr_t wr_req;
   ssc_pkg::ssc_filt_t filt_cfg;
   logic [6:0] rd_addr;
   logic [15:0] rd_data;
   logic [11:0] aux_level_out;
   logic [1:0] line_in = 2'b00, line_out, line_oe, al_en = 2'b00, al_lvl = 2'b00;
   logic data_update = 1'b0, st_fail = 1'b1, st_clr = 1'b0, st_act, st_err;
   logic stim_neg, stim_pos, bias_en, orig_en;
   logic nv_ld = 1'b0;
   logic [15:0] nv_w = 16'h0000, nv_rw;
   int bad_count = 0;
   int checked = 0;
   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;
   ssc_bank #(.SELFTEST_CYCLES(16)) dut (.core_clk(core_clk), .rst(rst), .wr_req(wr_req),
      .rd_addr(rd_addr), .rd_data(rd_data), .nv_load(nv_ld), .nv_word(nv_w),
      .nv_range_word(nv_rw), .filt_cfg(filt_cfg), .aux_level_out(aux_level_out),
      .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .alarm_line_en(al_en),
      .alarm_line_lvl(al_lvl), .data_update(data_update), .selftest_active(st_act),
      .selftest_fail(st_fail), .status_clear(st_clr), .status_selftest_err(st_err),
      .stim_neg(stim_neg), .stim_pos(stim_pos), .bias_comp_en(bias_en),
      .origin_align_en(orig_en));
   ssc_host h (.core_clk(core_clk), .rd_data(rd_data), .wr_req(wr_req), .rd_addr(rd_addr));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Read through the host and compare
   task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] v;
      h.rd_word(a, v);
      chk(v, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // One-cycle pulse on a same-clock input
   task automatic upd();
      @(negedge core_clk);
      data_update = 1'b1;
      @(negedge core_clk);
      data_update = 1'b0;
   endtask
   task automatic end_sim();
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog: 4000 cycles, and the sequence needs well under that
   initial begin
      #20000;
      bad_count++;
      end_sim();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      settle(6);
      rst = 1'b0;
      rchk(7'h30, 16'h0000);
      rchk(7'h32, 16'h0000);
      rchk(7'h38, 16'h0402);
      // Each range with a zero filter request: mid and narrow raise it to their floor
      for (int i = 0; i < 3; i++) begin
         h.set_range(8'(4 >> i), 8'h00);
         rchk(7'h38, {5'h0, 3'(4 >> i), 8'(2 * i)});
         chk(16'(filt_cfg.range), 16'(i));
      end
      h.wr_byte(7'h39, 8'h03);
      rchk(7'h38, 16'h0104);
      h.set_range(8'h04, 8'h00);
      for (int m = 0; m < 8; m++) begin
         h.wr_byte(7'h38, 8'(m));
         chk(16'(filt_cfg.taps), 16'h1 << m);
         chk(16'(filt_cfg.filt_m), 16'(m));
      end
      // Staged converter word stays off the output until latched
      h.aux_stage(16'hfcab);
      chk({4'h0, aux_level_out}, 16'h0000);
      rchk(7'h30, 16'h0cab);
      h.aux_latch();
      settle(2);
      chk({4'h0, aux_level_out}, 16'h0cab);
      // Lines as outputs, then as inputs
      h.wr_byte(7'h32, 8'h03);
      h.wr_byte(7'h33, 8'h02);
      settle(1);
      chk({14'h0, line_oe}, 16'h0003);
      chk({14'h0, line_out}, 16'h0002);
      h.wr_byte(7'h32, 8'h00);
      line_in = 2'b01;
      settle(3);
      rchk(7'h32, 16'h0100);
      chk({14'h0, line_oe}, 16'h0000);
      // Data-ready on line two beats alarm; alarm beats line control
      h.wr_byte(7'h32, 8'h03);
      h.wr_byte(7'h33, 8'h03);
      al_en = 2'b11;
      al_lvl = 2'b10;
      h.wr_byte(7'h34, 8'h05);
      upd();
      settle(2);
      chk({14'h0, line_out}, 16'h0000);
      h.wr_byte(7'h34, 8'h07);
      upd();
      settle(2);
      chk({14'h0, line_out}, 16'h0002);
      // Pulse runs out after 32 cycles: line two back to inactive low
      settle(32);
      chk({14'h0, line_out}, 16'h0000);
      al_en = 2'b00;
      h.wr_byte(7'h34, 8'hc0);
      h.wr_byte(7'h35, 8'h03);
      settle(2);
      chk({14'h0, line_out}, 16'h0003);
      chk({12'h0, stim_neg, stim_pos, bias_en, orig_en}, 16'h000f);
      rchk(7'h34, 16'h03c0);
      // Self-test with a failing result, then the status clear
      h.wr_byte(7'h35, 8'h07);
      settle(1);
      chk({15'h0, st_act}, 16'h0001);
      settle(14);
      chk({15'h0, st_act}, 16'h0001);
      settle(1);
      chk({15'h0, st_act}, 16'h0000);
      chk({15'h0, st_err}, 16'h0001);
      rchk(7'h34, 16'h03c0);
      st_clr = 1'b1;
      settle(1);
      st_clr = 1'b0;
      settle(1);
      chk({15'h0, st_err}, 16'h0000);
      // Passing self-test leaves the failure flag low
      st_fail = 1'b0;
      h.wr_byte(7'h35, 8'h04);
      settle(16);
      chk({14'h0, st_act, st_err}, 16'h0000);
      // Second reset clears the converter; range word restored from store
      h.aux_stage(16'h0123);
      h.aux_latch();
      chk({4'h0, aux_level_out}, 16'h0123);
      rst = 1'b1;
      settle(2);
      rst = 1'b0;
      chk({4'h0, aux_level_out}, 16'h0000);
      rchk(7'h30, 16'h0000);
      rchk(7'h38, 16'h0402);
      nv_w = 16'hf9fd;
      nv_ld = 1'b1;
      settle(1);
      nv_ld = 1'b0;
      settle(1);
      chk(nv_rw, 16'h0105);
      rchk(7'h38, 16'h0105);
      rchk(7'h3e, 16'h0000);
      rchk(7'h20, 16'h0000);
      end_sim();
   end
endmodule
